// file: logic/ssc_core.sv
// control front end of a synchronous burst sram with its storage array
`timescale 1ns/100ps

module ssc_core #(
  parameter int ADDR_W = ssc_pkg::ADDR_W,
  parameter int FIFO_DEPTH = ssc_pkg::FIFO_DEPTH
) (
  input wire logic clk,
  input wire logic rst,
  input wire ssc_pkg::ssc_ctl_t ctl,
  input wire logic [ADDR_W-1:0] addr_in,
  input wire logic output_enable_n,
  input wire logic burst_order_strap,
  input wire logic [ssc_pkg::DATA_W-1:0] dq_i,
  output logic [ssc_pkg::DATA_W-1:0] dq_o,
  output logic dq_oe,
  output logic wr_ready
);

  localparam int CW = ssc_pkg::CNT_W;
  localparam int WORDS = 2 ** ADDR_W;

  // ********************************************************
  // selection and address load
  // ********************************************************
  ssc_pkg::ssc_state_t state_q, state_d;
  logic [ADDR_W-1:0] addr_q, addr_d;
  logic [CW-1:0] seed_q, seed_d;
  logic [CW-1:0] step_q, step_d;
  logic linear_q, linear_d;
  logic sel_in, proc_take, ctrl_take, load, access;
  logic [CW-1:0] burst_low;
  logic [ADDR_W-1:0] cur_addr;
  logic [CW-1:0] burst_seed_bits;

  assign burst_seed_bits = addr_in[CW-1:0];

  always_comb begin
    sel_in = ~ctl.first_chip_enable_low & ctl.second_chip_enable_high
      & ~ctl.third_chip_enable_low;
    proc_take = ~ctl.processor_address_strobe_n & ~ctl.first_chip_enable_low;
    ctrl_take = ~ctl.controller_address_strobe_n & ~proc_take;
    load = proc_take | ctrl_take;
    access = (state_q != ssc_pkg::SSC_DESEL) & ~load;
    burst_low = linear_q ? seed_q + step_q : seed_q ^ step_q;
    cur_addr = {addr_q[ADDR_W-1:CW], burst_low};
    state_d = state_q;
    addr_d = addr_q;
    seed_d = seed_q;
    step_d = step_q;
    linear_d = linear_q;
    if (rst) begin
      linear_d = ~burst_order_strap;
    end
    if (load) begin
      // enables decoded only here; the first enable also gates the processor strobe
      if (sel_in) begin
        addr_d = addr_in;
        seed_d = burst_seed_bits;
        step_d = ssc_pkg::CNT_ZERO;
        state_d = (state_q == ssc_pkg::SSC_DESEL) ? ssc_pkg::SSC_FIRST : ssc_pkg::SSC_SEL;
      end else begin
        state_d = ssc_pkg::SSC_DESEL;
      end
    end else if (access) begin
      if (~ctl.burst_advance_n) begin
        step_d = step_q + ssc_pkg::CNT_ONE;
      end
      if (state_q == ssc_pkg::SSC_FIRST) begin
        state_d = ssc_pkg::SSC_SEL;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state_q <= ssc_pkg::SSC_DESEL;
      addr_q <= '0;
      seed_q <= ssc_pkg::CNT_ZERO;
      step_q <= ssc_pkg::CNT_ZERO;
    end else begin
      state_q <= state_d;
      addr_q <= addr_d;
      seed_q <= seed_d;
      step_q <= step_d;
    end
    linear_q <= linear_d;
  end

  // ********************************************************
  // write qualification and queue
  // ********************************************************
  logic [ssc_pkg::LANES-1:0] wr_lanes;
  logic wr_cycle, rd_cycle, drain_ready, drain_valid;
  ssc_pkg::ssc_wr_t wr_in, wr_out;

  always_comb begin
    if (~ctl.all_lanes_write_n) begin
      wr_lanes = ssc_pkg::LANES_ALL;
    end else if (~ctl.byte_write_qualifier_n) begin
      wr_lanes = ~ctl.lane_write_select_n;
    end else begin
      wr_lanes = ssc_pkg::LANES_NONE;
    end
    wr_cycle = access & (wr_lanes != ssc_pkg::LANES_NONE);
    rd_cycle = access & ~wr_cycle;
    wr_in.addr = cur_addr;
    wr_in.lanes = wr_lanes;
    wr_in.data = dq_i;
    // array is single ported: reads stall the drain
    drain_ready = ~rd_cycle;
  end

  ssc_fifo #(
    .WIDTH($bits(ssc_pkg::ssc_wr_t)),
    .DEPTH(FIFO_DEPTH)
  ) u_wr_fifo (
    .clk(clk),
    .rst(rst),
    .in_valid(wr_cycle),
    .in_ready(wr_ready),
    .in_data(wr_in),
    .out_valid(drain_valid),
    .out_ready(drain_ready),
    .out_data(wr_out)
  );

  // ********************************************************
  // array and read path
  // ********************************************************
  logic [ssc_pkg::DATA_W-1:0] rd_word;
  logic [ssc_pkg::DATA_W-1:0] rd_q, rd_d;
  logic drive_q, drive_d;

  always_comb begin
    rd_d = rd_cycle ? rd_word : rd_q;
    drive_d = rd_cycle & (state_q == ssc_pkg::SSC_SEL);
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      rd_q <= '0;
      drive_q <= 1'b0;
    end else begin
      rd_q <= rd_d;
      drive_q <= drive_d;
    end
  end

  // one array per lane so each lane has a single writer
  for (genvar g = 0; g < ssc_pkg::LANES; g++) begin : g_lane
    logic [ssc_pkg::LANE_W-1:0] lane_q [WORDS];
    always_ff @(posedge clk) begin
      if (drain_valid & drain_ready & wr_out.lanes[g]) begin
        lane_q[wr_out.addr] <= wr_out.data[g*ssc_pkg::LANE_W +: ssc_pkg::LANE_W];
      end
    end
    assign rd_word[g*ssc_pkg::LANE_W +: ssc_pkg::LANE_W] = lane_q[cur_addr];
  end

  assign dq_o = rd_q;
  assign dq_oe = drive_q & ~output_enable_n;

  // ********************************************************
  // checks
  // ********************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_load_addr_seed: assert property (load & sel_in |=> addr_q == $past(addr_in)
    && seed_q == $past(addr_in[CW-1:0]) && step_q == ssc_pkg::CNT_ZERO)
    else $error("selected strobe did not latch address and seed");
  a_deselect_combo: assert property (load & ~sel_in |=> state_q == ssc_pkg::SSC_DESEL)
    else $error("bad enable combination did not deselect");
  a_proc_strobe_ignored: assert property (ctl.first_chip_enable_low
    & ~ctl.processor_address_strobe_n & ctl.controller_address_strobe_n
    |=> $stable(addr_q) && $stable(seed_q))
    else $error("processor strobe acted while first enable high");
  a_enables_ignored: assert property (access & ctl.burst_advance_n |=>
    $stable(addr_q) && $stable(step_q) && state_q != ssc_pkg::SSC_DESEL)
    else $error("enables affected a continuation cycle");
  a_advance_step: assert property (access & ~ctl.burst_advance_n |=>
    step_q == $past(step_q) + ssc_pkg::CNT_ONE)
    else $error("burst counter did not advance");
  a_no_drive_write: assert property (wr_cycle |=> !dq_oe)
    else $error("data pins driven during write data phase");
  a_desel_quiet: assert property (state_q == ssc_pkg::SSC_DESEL |-> !dq_oe)
    else $error("data pins driven while deselected");
  a_first_read_mask: assert property (state_q == ssc_pkg::SSC_FIRST & access |=> !dq_oe)
    else $error("data pins driven in first clock after deselect");
  a_oe_gates_pins: assert property (output_enable_n |-> !dq_oe)
    else $error("data pins driven with output enable high");
  a_global_lanes: assert property (~ctl.all_lanes_write_n
    |-> wr_lanes == ssc_pkg::LANES_ALL)
    else $error("all-lanes write did not enable every lane");
  a_byte_lanes: assert property (ctl.all_lanes_write_n & ctl.byte_write_qualifier_n
    |-> wr_lanes == ssc_pkg::LANES_NONE)
    else $error("lane written without byte write qualifier");
  a_lane_selects: assert property (ctl.all_lanes_write_n & ~ctl.byte_write_qualifier_n
    |-> wr_lanes == ~ctl.lane_write_select_n)
    else $error("qualified byte write enabled wrong lanes");
  a_both_strobes: assert property (~ctl.processor_address_strobe_n
    & ~ctl.controller_address_strobe_n & ~ctl.first_chip_enable_low
    |-> proc_take & ~ctrl_take)
    else $error("controller strobe won over processor strobe");

  c_burst_read: cover property (rd_cycle ##1 rd_cycle ##1 dq_oe);
  c_global_write: cover property (wr_cycle & ~ctl.all_lanes_write_n);
  c_interleave_burst: cover property (~linear_q & access & ~ctl.burst_advance_n);
  c_deselect: cover property (load & ~sel_in ##1 load & sel_in);

endmodule

// file: logic/ssc_pkg.sv
// shared constants and carrier types for the burst sram control front end
package ssc_pkg;

  localparam int ADDR_W = 8;
  localparam int LANES = 4;
  localparam int LANE_W = 9;
  localparam int DATA_W = LANES * LANE_W;
  localparam int CNT_W = 2;
  localparam int FIFO_DEPTH = 16;
  localparam logic [CNT_W-1:0] CNT_ZERO = 2'h0;
  localparam logic [CNT_W-1:0] CNT_ONE = 2'h1;
  localparam logic [LANES-1:0] LANES_ALL = 4'hF;
  localparam logic [LANES-1:0] LANES_NONE = 4'h0;

  // synchronous control pins, all sampled on the rising edge
  typedef struct packed {
    logic processor_address_strobe_n;
    logic controller_address_strobe_n;
    logic burst_advance_n;
    logic first_chip_enable_low;
    logic second_chip_enable_high;
    logic third_chip_enable_low;
    logic all_lanes_write_n;
    logic byte_write_qualifier_n;
    logic [LANES-1:0] lane_write_select_n;
  } ssc_ctl_t;

  // one queued write: word address, lane mask, data with parity per lane
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [LANES-1:0] lanes;
    logic [DATA_W-1:0] data;
  } ssc_wr_t;

  typedef enum logic [1:0] {
    SSC_DESEL = 2'b00,
    SSC_FIRST = 2'b01,
    SSC_SEL = 2'b10
  } ssc_state_t;

endpackage

// file: logic/ssc_fifo.sv
// parameterised valid/ready fifo for queued writes
`timescale 1ns/100ps
module ssc_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);

  localparam int PW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [PW-1:0] wr_ptr_q, wr_ptr_d, rd_ptr_q, rd_ptr_d;
  logic [PW:0] count_q, count_d;
  logic push, pop;

  assign in_ready = (count_q != DEPTH[PW:0]);
  assign out_valid = (count_q != '0);
  assign out_data = mem_q[rd_ptr_q];

  always_comb begin
    push = in_valid & in_ready;
    pop = out_valid & out_ready;
    wr_ptr_d = push ? wr_ptr_q + 1'b1 : wr_ptr_q;
    rd_ptr_d = pop ? rd_ptr_q + 1'b1 : rd_ptr_q;
    count_d = count_q;
    if (push & ~pop) begin
      count_d = count_q + 1'b1;
    end else if (pop & ~push) begin
      count_d = count_q - 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q <= '0;
    end else begin
      wr_ptr_q <= wr_ptr_d;
      rd_ptr_q <= rd_ptr_d;
      count_q <= count_d;
    end
    if (push) begin
      mem_q[wr_ptr_q] <= in_data;
    end
  end

endmodule

// file: bench/ssc_host_model.sv
// host-side model driving the control, address and write data pins
`timescale 1ns/100ps
module ssc_host_model (
  input wire logic clk,
  output ssc_pkg::ssc_ctl_t ctl,
  output logic [ssc_pkg::ADDR_W-1:0] addr_in,
  output logic [ssc_pkg::DATA_W-1:0] dq_i
);
  initial begin
    ctl = '1;
    addr_in = '0;
    dq_i = '0;
  end
  // one cycle: drive after the falling edge, hold across the rising edge
  task automatic step(input ssc_pkg::ssc_ctl_t c, input logic [7:0] a, input logic [35:0] d);
    logic wr;
    logic ld;
    wr = !c.all_lanes_write_n || !c.byte_write_qualifier_n;
    ld = !c.processor_address_strobe_n || !c.controller_address_strobe_n;
    @(negedge clk);
    ctl = c;
    // idle pins toggle so stale values never look valid
    addr_in = ld ? a : ~addr_in;
    dq_i = wr ? d : ~dq_i;
    @(posedge clk);
    #1;
  endtask
endmodule

// file: bench/tb.sv
// self-checking bench for the burst sram control front end
`timescale 1ns/100ps
module tb;
  localparam logic [2:0] SEL = 3'h2;
  logic clk;
  logic rst;
  logic oe_n;
  logic strap;
  ssc_pkg::ssc_ctl_t ctl;
  logic [7:0] addr_in;
  logic [35:0] dq_i;
  logic [35:0] dq_o;
  logic dq_oe;
  logic wr_ready;
  logic [35:0] mem [256];
  logic [7:0] ab;
  logic [1:0] sd;
  logic [1:0] st;
  logic dsl;
  logic fresh;
  int bad_count = 0;
  int cmp_count = 0;
  int cyc_count = 0;

  ssc_core u_dut (.clk(clk), .rst(rst), .ctl(ctl), .addr_in(addr_in), .output_enable_n(oe_n),
    .burst_order_strap(strap), .dq_i(dq_i), .dq_o(dq_o), .dq_oe(dq_oe), .wr_ready(wr_ready));
  ssc_host_model u_host (.clk(clk), .ctl(ctl), .addr_in(addr_in), .dq_i(dq_i));

  initial begin
    clk = 1'h0;
    forever #20 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc_count++;
    if (cyc_count == 20000) begin
      bad_count++;
      tally_and_finish();
    end
  end

  // ****************************************
  // helpers
  // ****************************************
  task automatic chk(input logic [35:0] seen, input logic [35:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic rs(input logic s);
    @(negedge clk);
    rst = 1'h1;
    strap = s;
    repeat (16) @(negedge clk);
    rst = 1'h0;
    dsl = 1'h1;
    fresh = 1'h0;
    chk(36'(dq_oe), 36'h0);
    chk(dq_o, 36'h0);
    chk(36'(wr_ready), 36'h1);
  endtask
  // one cycle plus reference model of load, write and read
  task automatic cyc(input logic [11:0] b, input logic [7:0] a, input logic [35:0] d);
    ssc_pkg::ssc_ctl_t c;
    logic [3:0] m;
    logic [7:0] wa;
    c = b;
    m = !c.all_lanes_write_n ? 4'hF : !c.byte_write_qualifier_n ? ~c.lane_write_select_n : 4'h0;
    wa = {ab[7:2], strap ? sd ^ st : sd + st};
    u_host.step(c, a, d);
    if ((!c.processor_address_strobe_n && !c.first_chip_enable_low)
        || !c.controller_address_strobe_n) begin
      fresh = dsl && b[8:6] == SEL;
      dsl = b[8:6] != SEL;
      ab = a;
      sd = a[1:0];
      st = 2'h0;
      chk(36'(dq_oe), 36'h0);
    end else if (dsl) begin
      chk(36'(dq_oe), 36'h0);
    end else begin
      if (m != 4'h0) begin
        for (int g = 0; g < 4; g++) begin
          if (m[g]) mem[wa][9*g +: 9] = d[9*g +: 9];
        end
        chk(36'(dq_oe), 36'h0);
        chk(36'(wr_ready), 36'h1);
      end else begin
        chk(dq_o, mem[wa]);
        chk(36'(dq_oe), 36'(!fresh && !oe_n));
      end
      fresh = 1'h0;
      if (!c.burst_advance_n) st = st + 2'h1;
    end
  endtask
  task automatic ld(input logic p, input logic [2:0] ce, input logic [7:0] a);
    cyc({p ? 2'h1 : 2'h2, 1'h1, ce, 6'h3F}, a, 36'h0);
  endtask
  task automatic ac(input logic burst_advance, input logic [5:0] w, input logic [35:0] d);
    cyc({2'h3, burst_advance, 3'h5, w}, 8'h00, d);
  endtask
  task automatic dr(input logic [7:0] a);
    repeat (17) ld(1'h0, SEL, a);
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_writes();
    ld(1'h0, SEL, 8'h10);
    ac(1'h1, 6'h1F, 36'h1_2345_6789);
    ac(1'h1, 6'h2A, 36'hA_BCDE_F012);
    dr(8'h10);
    ac(1'h1, 6'h30, 36'h0);
    oe_n = 1'h1;
    #1;
    chk(36'(dq_oe), 36'h0);
    oe_n = 1'h0;
    #1;
    chk(36'(dq_oe), 36'h1);
  endtask
  task automatic t_strobes();
    ld(1'h0, SEL, 8'h14);
    cyc({2'h0, 1'h1, SEL, 6'h3F}, 8'h10, 36'h0);
    ac(1'h1, 6'h3F, 36'h0);
    cyc({2'h1, 1'h1, 3'h6, 6'h3F}, 8'h14, 36'h0);
  endtask
  task automatic t_deselect();
    for (int i = 0; i < 8; i++) begin
      if (3'(i) != SEL) begin
        ld(1'h0, 3'(i), 8'h10);
        ac(1'h1, 6'h3F, 36'h0);
      end
    end
    ld(1'h1, SEL, 8'h10);
    ac(1'h1, 6'h3F, 36'h0);
    ac(1'h1, 6'h3F, 36'h0);
  endtask
  task automatic t_burst(input logic s);
    rs(s);
    ld(1'h1, SEL, 8'h21);
    for (int k = 0; k < 4; k++) begin
      ac(1'h0, 6'h1F, {4{9'(k) + 9'h0A5}});
    end
    dr(8'h21);
    for (int k = 0; k < 4; k++) begin
      ld(1'h0, SEL, 8'h20 + 8'(k));
      ac(1'h1, 6'h3F, 36'h0);
    end
  endtask

  initial begin
    oe_n = 1'h0;
    rst = 1'h1;
    rs(1'h0);
    t_writes();
    t_strobes();
    t_deselect();
    t_burst(1'h0);
    t_burst(1'h1);
    tally_and_finish();
  end
endmodule
